// file: relay_points_defines.vh
// constants for the relay serial data point bank
`ifndef RELAY_POINTS_DEFINES_VH
`define RELAY_POINTS_DEFINES_VH

// ---------------------------------------------------------------
// channel and item codes
// ---------------------------------------------------------------
`define CHANNEL_MAIN        8'h00
`define KIND_INPUT          2'h0
`define KIND_OUTPUT         2'h1
`define ITEM_PHASE1         8'h01
`define ITEM_PHASE2         8'h02
`define ITEM_PHASE3         8'h03
`define ITEM_NEUTRAL        8'h04
`define ITEM_BLOCKING       8'h05
`define ITEM_FLAG_FIRST     8'h01
`define ITEM_FLAG_LAST      8'h08
`define ITEM_OUT_FIRST      8'h09
`define ITEM_OUT_LAST       8'h0D
`define ITEM_OPERATE        8'h29

// ---------------------------------------------------------------
// reset values and answer codes
// ---------------------------------------------------------------
`define OUT_RESET           5'h00
`define OPERATE_RESET       1'h0
`define STATUS_OK           2'h0
`define STATUS_READ_ONLY    2'h1
`define STATUS_LOCKED       2'h2
`define STATUS_UNKNOWN      2'h3

`endif

// file: relay_item_decode.v
// decoder from channel, kind and item number to a data point selector
`timescale 1ns/1ps
`include "relay_points_defines.vh"

module relay_item_decode (
    input  wire [7:0] channel,
    input  wire [1:0] kind,
    input  wire [7:0] item,
    output reg        hit_current,
    output reg        hit_blocking,
    output reg        hit_flag,
    output reg        hit_output,
    output reg        hit_operate,
    output reg  [3:0] index
);

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    // only channel zero carries data points
    always @* begin
        hit_current  = 1'b0;
        hit_blocking = 1'b0;
        hit_flag     = 1'b0;
        hit_output   = 1'b0;
        hit_operate  = 1'b0;
        index        = 4'h0;
        if (channel == `CHANNEL_MAIN) begin // R1
            if (kind == `KIND_INPUT) begin
                if (item >= `ITEM_PHASE1 && item <= `ITEM_NEUTRAL) begin
                    hit_current = 1'b1;
                    index       = item[3:0] - 4'h1;
                end else if (item == `ITEM_BLOCKING) begin
                    hit_blocking = 1'b1;
                end
            end else if (kind == `KIND_OUTPUT) begin
                if (item >= `ITEM_FLAG_FIRST && item <= `ITEM_FLAG_LAST) begin
                    hit_flag = 1'b1;
                    index    = item[3:0] - 4'h1;
                end else if (item >= `ITEM_OUT_FIRST && item <= `ITEM_OUT_LAST) begin
                    hit_output = 1'b1;
                    index      = item[3:0] - 4'h9;
                end else if (item == `ITEM_OPERATE) begin
                    hit_operate = 1'b1;
                end
            end
        end
    end

endmodule // relay_item_decode

// file: relay_serial_data_points.v
// data point bank of a protection relay module seen from the serial bus
// What this block does
// R1: every data item is reached through channel 0 only.
// R2: the communicator, never this module, makes the three link status events.
// R3: the module answers reads of all its input and output data items.
// R4: password-protected items take a write only after password enablement.
// R5: three phase currents (0..63 x rated) and neutral current (0..210 %) are read-only.
// R6: the blocking item reads 1 while external blocking is active, else 0.
// R7: eight read-only flags give start and trip of the four protection stages.
// R8: five output signals are readable and writable under password.
// R9: writing 1 to the operate item operates the relays, 0 releases, reads give state.
// R10: a protected write without enablement is refused and changes nothing.
// R11: a write to a read-only item is refused and changes nothing.
`timescale 1ns/1ps
`include "relay_points_defines.vh"

// ---------------------------------------------------------------
// item map
// ---------------------------------------------------------------
// channel 0 holds every item; other channels answer unknown
// kind 0, items 1..3: phase currents, full width, read only
// kind 0, item 4: neutral current, full width, read only
// kind 0, item 5: blocking input in bit 0, read only
// kind 1, items 1..8: stage flags in bit 0, read only
// flag order: low phase start, trip, high phase start, trip,
// then low neutral start, trip, high neutral start, trip
// kind 1, items 9..13: output lines in bit 0, password writable
// line order: primary trip, first start, first alarm,
// second alarm, main trip
// kind 1, item 41: relay operate bit, password writable
// ---------------------------------------------------------------
// answer and timing
// ---------------------------------------------------------------
// status 0 taken, 1 read only, 2 locked, 3 unknown item
// a request is taken at a rising edge with req_valid high
// its answer pulse follows one edge later, one per request
// requests may come back to back in every cycle
// a write answers with the value it replaces
// refused requests change no stored state
// limitation: a written line stays forced until reset, since the
// bus has no item that hands a line back to the stage logic

module relay_serial_data_points #(
    parameter CUR_W = 16
) (
    // clock and synchronous reset
    input  wire             clock,
    input  wire             resetn,
    // request from the communicator
    input  wire             req_valid,
    input  wire             req_write,
    input  wire [7:0]       req_channel,
    input  wire [1:0]       req_kind,
    input  wire [7:0]       req_item,
    input  wire [CUR_W-1:0] req_data,
    input  wire             password_enabled,
    // measured values and live protection state
    input  wire [CUR_W-1:0] phase1_current,
    input  wire [CUR_W-1:0] phase2_current,
    input  wire [CUR_W-1:0] phase3_current,
    input  wire [CUR_W-1:0] neutral_current,
    input  wire             blocking_input,
    input  wire [7:0]       stage_flags,
    input  wire [4:0]       output_signals_in,
    // answer to the communicator
    output reg              ans_valid,
    output reg  [1:0]       ans_status,
    output reg  [CUR_W-1:0] ans_data,
    // line control toward the output stage
    output reg  [4:0]       output_override,
    output reg  [4:0]       output_force,
    output reg              relay_operate
);

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    // item decoder; at most one hit is high for any request
    wire       hit_current;
    wire       hit_blocking;
    wire       hit_flag;
    wire       hit_output;
    wire       hit_operate;
    wire [3:0] index;

    relay_item_decode u_decode (
        .channel      (req_channel),
        .kind         (req_kind),
        .item         (req_item),
        .hit_current  (hit_current),
        .hit_blocking (hit_blocking),
        .hit_flag     (hit_flag),
        .hit_output   (hit_output),
        .hit_operate  (hit_operate),
        .index        (index)
    );

    // present state of one output line: forced value wins over the stage logic
    function out_state;
        input [4:0] ovr;
        input [4:0] frc;
        input [4:0] raw;
        input [3:0] idx;
        begin
            out_state = ovr[idx[2:0]] ? frc[idx[2:0]] : raw[idx[2:0]];
        end
    endfunction

    // one-hot enable for the output line picked by an item index
    function [4:0] line_select;
        input [3:0] idx;
        begin
            line_select = 5'h01 << idx[2:0];
        end
    endfunction

    // answer code of a request; the first refusal that applies wins
    function [1:0] answer_code;
        input unknown;
        input readonly;
        input locked;
        begin
            if (unknown) begin
                answer_code = `STATUS_UNKNOWN;
            end else if (readonly) begin
                answer_code = `STATUS_READ_ONLY;
            end else if (locked) begin
                answer_code = `STATUS_LOCKED;
            end else begin
                answer_code = `STATUS_OK;
            end
        end
    endfunction

    // ---------------------------------------------------------------
    // named views of the stage flags
    // ---------------------------------------------------------------
    // bit order of stage_flags follows the item numbers 1 to 8
    wire low_phase_start_flag;
    wire low_phase_trip_flag;
    wire high_phase_start_flag;
    wire high_phase_trip_flag;
    wire low_neutral_start_flag;
    wire low_neutral_trip_flag;
    wire high_neutral_start_flag;
    wire high_neutral_trip_flag;

    assign low_phase_start_flag    = stage_flags[0];
    assign low_phase_trip_flag     = stage_flags[1];
    assign high_phase_start_flag   = stage_flags[2];
    assign high_phase_trip_flag    = stage_flags[3];
    assign low_neutral_start_flag  = stage_flags[4];
    assign low_neutral_trip_flag   = stage_flags[5];
    assign high_neutral_start_flag = stage_flags[6];
    assign high_neutral_trip_flag  = stage_flags[7];

    // ---------------------------------------------------------------
    // present state of the output lines
    // ---------------------------------------------------------------
    // forced value wins once a line has been written
    wire primary_trip_output;
    wire first_start_output;
    wire first_alarm_output;
    wire second_alarm_output;
    wire main_trip_output;

    assign primary_trip_output = out_state(output_override, output_force,
                                           output_signals_in, 4'h0); // R8
    assign first_start_output  = out_state(output_override, output_force,
                                           output_signals_in, 4'h1);
    assign first_alarm_output  = out_state(output_override, output_force,
                                           output_signals_in, 4'h2);
    assign second_alarm_output = out_state(output_override, output_force,
                                           output_signals_in, 4'h3);
    assign main_trip_output    = out_state(output_override, output_force,
                                           output_signals_in, 4'h4);

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    // each group has its own small mux and the final pick only steers;
    // unused high bits of single-bit items read as zero
    reg [CUR_W-1:0] current_value;
    reg             flag_value;
    reg             line_value;
    reg [CUR_W-1:0] read_value;
    wire            hit_any;

    assign hit_any = hit_current | hit_blocking | hit_flag | hit_output | hit_operate;

    // measured currents, full width
    always @* begin
        case (index[1:0]) // R5
            2'h0:    current_value = phase1_current;
            2'h1:    current_value = phase2_current;
            2'h2:    current_value = phase3_current;
            default: current_value = neutral_current;
        endcase
    end

    // stage flags in item order
    always @* begin
        case (index[2:0]) // R7
            3'h0:    flag_value = low_phase_start_flag;
            3'h1:    flag_value = low_phase_trip_flag;
            3'h2:    flag_value = high_phase_start_flag;
            3'h3:    flag_value = high_phase_trip_flag;
            3'h4:    flag_value = low_neutral_start_flag;
            3'h5:    flag_value = low_neutral_trip_flag;
            3'h6:    flag_value = high_neutral_start_flag;
            default: flag_value = high_neutral_trip_flag;
        endcase
    end

    // output lines in item order
    always @* begin
        case (index[2:0]) // R8
            3'h0:    line_value = primary_trip_output;
            3'h1:    line_value = first_start_output;
            3'h2:    line_value = first_alarm_output;
            3'h3:    line_value = second_alarm_output;
            default: line_value = main_trip_output;
        endcase
    end

    // final pick between the groups
    always @* begin
        read_value = {CUR_W{1'b0}};
        if (hit_current) begin
            read_value = current_value;
        end else if (hit_blocking) begin
            read_value[0] = blocking_input; // R6
        end else if (hit_flag) begin
            read_value[0] = flag_value;
        end else if (hit_output) begin
            read_value[0] = line_value;
        end else if (hit_operate) begin
            read_value[0] = relay_operate; // R9
        end
    end

    // ---------------------------------------------------------------
    // request classification
    // ---------------------------------------------------------------
    // each request lands in one class; the decoder's hits are one-hot,
    // so a read-only hit and a protected hit never meet
    wire protected_hit;
    wire readonly_hit;
    wire refuse_unknown;
    wire refuse_readonly;
    wire refuse_locked;
    wire take_write;

    assign protected_hit   = hit_output | hit_operate;
    assign readonly_hit    = hit_current | hit_blocking | hit_flag;
    assign refuse_unknown  = ~hit_any; // R1
    assign refuse_readonly = req_write & readonly_hit; // R11
    assign refuse_locked   = req_write & protected_hit & ~password_enabled; // R10
    assign take_write      = req_valid & req_write & protected_hit & password_enabled; // R4

    // ---------------------------------------------------------------
    // next answer
    // ---------------------------------------------------------------
    // one answer per request, one cycle later; data is the value before
    // any write, so a write also reports what it replaced
    reg             next_ans_valid;
    reg [1:0]       next_ans_status;
    reg [CUR_W-1:0] next_ans_data;

    always @* begin
        next_ans_valid  = req_valid;
        next_ans_status = ans_status;
        next_ans_data   = ans_data;
        if (req_valid) begin
            next_ans_status = answer_code(refuse_unknown, refuse_readonly, refuse_locked);
            next_ans_data   = read_value; // R3
        end
    end

    // ---------------------------------------------------------------
    // next line control and operate state
    // ---------------------------------------------------------------
    // refused writes leave both vectors and the operate bit untouched
    reg [4:0] line_write;
    reg [4:0] next_output_override;
    reg [4:0] next_output_force;
    reg       next_relay_operate;

    always @* begin
        line_write = 5'h00;
        if (take_write && hit_output) begin
            line_write = line_select(index); // R8
        end
        next_output_override = output_override | line_write;
        next_output_force    = (output_force & ~line_write) | (line_write & {5{req_data[0]}});
    end

    // writing 0 releases the relays as well, so no separate release item
    always @* begin
        next_relay_operate = relay_operate;
        if (take_write && hit_operate) begin
            next_relay_operate = req_data[0]; // R9
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    // answer registers; reset leaves a zero answer with no pulse
    always @(posedge clock) begin
        if (!resetn) begin
            ans_valid  <= 1'b0;
            ans_status <= `STATUS_OK;
            ans_data   <= {CUR_W{1'b0}};
        end else begin
            ans_valid  <= next_ans_valid;
            ans_status <= next_ans_status;
            ans_data   <= next_ans_data;
        end
    end

    // line overrides hold until reset; the bus cannot hand a line
    // back to the stage logic
    always @(posedge clock) begin
        if (!resetn) begin
            output_override <= `OUT_RESET;
            output_force    <= `OUT_RESET;
        end else begin
            output_override <= next_output_override;
            output_force    <= next_output_force;
        end
    end

    // operate command
    always @(posedge clock) begin
        if (!resetn) begin
            relay_operate <= `OPERATE_RESET;
        end else begin
            relay_operate <= next_relay_operate;
        end
    end

endmodule // relay_serial_data_points

// file: relay_points_checker_assertions.sv
// assertion checker for the relay data point bank
`timescale 1ns/1ps
module relay_points_checker #(parameter CUR_W = 16) (
    input wire clock, resetn, req_valid, req_write, password_enabled, blocking_input,
    input wire [7:0] req_channel, req_item, stage_flags,
    input wire [1:0] req_kind, ans_status,
    input wire [CUR_W-1:0] req_data, phase1_current, ans_data,
    input wire ans_valid, relay_operate,
    input wire [4:0] output_override, output_force
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // decode of channel 0 requests
    wire rd = req_valid && !req_write && req_channel == 8'h00;
    wire wr = req_valid && req_write && req_channel == 8'h00;
    wire op = wr && req_kind == 2'h1 && req_item == 8'h29;
    property p_answer; req_valid |=> ans_valid; endproperty
    property p_quiet; !req_valid |=> !ans_valid; endproperty
    property p_channel; req_valid && req_channel != 8'h00 |=> ans_status == 2'h3; endproperty
    property p_ro; wr && req_kind == 2'h0 && req_item == 8'h03 |=> ans_status == 2'h1; endproperty
    property p_locked;
        op && !password_enabled |=> ans_status == 2'h2 && $stable(relay_operate);
    endproperty
    property p_operate; op && password_enabled |=> relay_operate == $past(req_data[0]); endproperty
    property p_phase;
        rd && req_kind == 2'h0 && req_item == 8'h01 |=> ans_data == $past(phase1_current);
    endproperty
    property p_block;
        rd && req_kind == 2'h0 && req_item == 8'h05 |=> ans_data[0] == $past(blocking_input);
    endproperty
    property p_flag;
        rd && req_kind == 2'h1 && req_item == 8'h08 |=> ans_data[0] == $past(stage_flags[7]);
    endproperty
    property p_out;
        wr && req_kind == 2'h1 && req_item == 8'h09 && password_enabled
            |=> output_override[0] && output_force[0] == $past(req_data[0]);
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    a_quiet: assert property (p_quiet) else $error("stray answer");
    a_channel: assert property (p_channel) else $error("other channel taken");
    a_ro: assert property (p_ro) else $error("input write taken");
    a_locked: assert property (p_locked) else $error("locked write taken");
    a_operate: assert property (p_operate) else $error("operate wrong");
    a_phase: assert property (p_phase) else $error("phase read wrong");
    a_block: assert property (p_block) else $error("blocking read wrong");
    a_flag: assert property (p_flag) else $error("flag read wrong");
    a_out: assert property (p_out) else $error("output write wrong");
    c_op: cover property (op && password_enabled);
    c_lock: cover property (op && !password_enabled);
    c_rd: cover property (rd && req_kind == 2'h0);
endmodule // relay_points_checker
bind relay_serial_data_points relay_points_checker #(.CUR_W(CUR_W)) chk_u (.*);

// file: communicator_model.sv
// communicator model issuing requests to the data point bank
`timescale 1ns/1ps
module communicator_model (
    input  wire        clock,
    output reg         req_valid = 1'h0,
    output reg         req_write = 1'h0,
    output reg  [7:0]  req_channel = 8'h00,
    output reg  [1:0]  req_kind = 2'h0,
    output reg  [7:0]  req_item = 8'h00,
    output reg  [15:0] req_data = 16'h0000
);
    // link status events stay here, the bank never makes them
    task xfer(input w, input [7:0] ch, input [1:0] k, input [7:0] it, input [15:0] d);
        @(negedge clock);
        {req_write, req_channel, req_kind, req_item, req_data} = {w, ch, k, it, d};
        req_valid = 1'h1;
        @(negedge clock);
        req_valid = 1'h0;
        req_data = ~d; // released data must not look held
    endtask
endmodule // communicator_model

// file: relay_serial_data_points_tb.sv
// self-checking bench for the relay data point bank
`timescale 1ns/1ps
module relay_serial_data_points_tb;
    reg clock = 1'h0, resetn = 1'h0, password_enabled = 1'h0, blocking_input = 1'h0, op = 1'h0;
    reg [15:0] phase1_current = 16'h0000, phase2_current = 16'h0000;
    reg [15:0] phase3_current = 16'h0000, neutral_current = 16'h0000;
    reg [7:0] stage_flags = 8'h00;
    reg [4:0] output_signals_in = 5'h00, ovr = 5'h00, frc = 5'h00;
    wire req_valid, req_write, ans_valid, relay_operate;
    wire [7:0] req_channel, req_item;
    wire [1:0] req_kind, ans_status;
    wire [15:0] req_data, ans_data;
    wire [4:0] output_override, output_force;
    integer miscompares = 0, checked = 0, i;
    reg [17:0] x;
    always #25 clock = ~clock;
    communicator_model comm_u (.*);
    relay_serial_data_points dut_u (.*);
    // expected {status, data}; unknown places answer 3 with zero data
    function [17:0] expect_ans(input w, input [7:0] ch, input [1:0] k, input [7:0] it);
        expect_ans = {2'h3, 16'h0000};
        if (ch == 8'h00 && k == 2'h0) case (it)
            8'h01: expect_ans = {1'h0, w, phase1_current};
            8'h02: expect_ans = {1'h0, w, phase2_current};
            8'h03: expect_ans = {1'h0, w, phase3_current};
            8'h04: expect_ans = {1'h0, w, neutral_current};
            8'h05: expect_ans = {1'h0, w, 15'h0000, blocking_input};
        endcase
        if (ch == 8'h00 && k == 2'h1 && it >= 8'h01 && it <= 8'h08)
            expect_ans = {1'h0, w, 15'h0000, stage_flags[it-1]};
        if (ch == 8'h00 && k == 2'h1 && it >= 8'h09 && it <= 8'h0D)
            expect_ans = {w && !password_enabled, 17'h00000 | (ovr[it-9] ? frc[it-9] : output_signals_in[it-9])};
        if (ch == 8'h00 && k == 2'h1 && it == 8'h29)
            expect_ans = {w && !password_enabled, 16'h0000, op};
    endfunction
    task check(input [8*8:1] name, input [15:0] seen, input [15:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("Error %0s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one request, its answer, then fresh inputs at the falling edge
    task run(input w, input [7:0] ch, input [1:0] k, input [7:0] it, input [15:0] d);
        x = expect_ans(w, ch, k, it);
        comm_u.xfer(w, ch, k, it, d);
        check("valid", {15'h0000, ans_valid}, 16'h0001);
        check("status", {14'h0000, ans_status}, {14'h0000, x[17:16]});
        if (x[17:16] == 2'h0 || x[17:16] == 2'h3) check("data", ans_data, x[15:0]);
        if (x[17:16] == 2'h0 && w && it == 8'h29) op = d[0];
        if (x[17:16] == 2'h0 && w && k == 2'h1 && it >= 8'h09 && it <= 8'h0D) begin
            ovr[it-9] = 1'h1;
            frc[it-9] = d[0];
        end
        check("operate", {15'h0000, relay_operate}, {15'h0000, op});
        check("override", {11'h000, output_override}, {11'h000, ovr});
        check("force", {11'h000, output_force}, {11'h000, frc});
        {phase1_current, phase2_current, phase3_current, neutral_current} = {$urandom, $urandom};
        {blocking_input, stage_flags, output_signals_in, password_enabled} = $urandom;
    endtask
    task final_report;
        if (miscompares == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // watchdog well past the 600 cycles the run needs
    initial begin
        #100000;
        miscompares = miscompares + 1;
        final_report;
    end
    // first four: operate refused, set, refused, released; then random traffic
    initial begin
        i = $urandom(81);
        repeat (2) @(posedge clock);
        @(negedge clock) resetn = 1'h1;
        for (i = 0; i < 300; i = i + 1) begin
            if (i < 4) password_enabled = i[0];
            run(i < 4 || $urandom % 2, i > 3 && $urandom % 8 == 0, i < 4 ? 2'h1 : $urandom % 3,
                (i < 4 || $urandom % 8 == 0) ? 8'h29 : $urandom % 15, i < 4 ? i < 2 : $urandom);
        end
        final_report;
    end
endmodule // relay_serial_data_points_tb
